/* dv/reload_timer_trigger_gate_bench.sv */
// self-checking bench for the reload timer trigger and gate control
`define CHK(nm, e, g) begin cmp_count++; if ((g) !== (e)) begin fails++; \
  $display("MISMATCH %s exp=%h got=%h", nm, e, g); end end
module reload_timer_trigger_gate_bench;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk_i, rst_i, cyc_i, stb_i, we_i, ack_o, pin, tpin, irq_o, go, lvl;
  logic [7:0] adr_i;
  logic [3:0] sel_i;
  logic [31:0] dat_i, dat_o, q, q1;
  logic [15:0] rl; // reload value of the current test
  logic [2:0] m;
  logic a; // active gate level
  int fails, cmp_count, seed, n;

  rtg_reload_timer #(.CNT_W(16)) u_dut (.clk_i(clk_i), .rst_i(rst_i),
    .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i), .adr_i(adr_i),
    .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o),
    .trigger_input_pin_i(pin), .timer_output_pin_o(tpin), .irq_o(irq_o));
  // slow source: every level stands four clocks, twice the minimum
  rtg_trig_src #(.HOLD(3)) u_src (.clk_i(clk_i), .rst_i(rst_i),
    .go_i(go), .lvl_i(lvl), .pin_o(pin));

  ////////////////////////////////////////////////////////////////////////
  // control word: mode, irq enable, count enable, software trigger
  function automatic logic [31:0] csr(input logic [2:0] md, input logic ie,
                                      input logic ce, input logic tg);
    return {25'h0, md, ie, 1'b0, ce, tg};
  endfunction
  // clocks from trigger to first toggle: load delay, count, wrap
  function automatic int exp_sw(input logic [15:0] r);
    return int'(r) + 2;
  endfunction
  function automatic int exp_ext(input logic [15:0] r);
    return int'(r) + 4;
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // one classic cycle; request held until ack is seen high
  task automatic wb(input logic w, input logic [7:0] ad, input logic [31:0] d);
    int k;
    @(posedge clk_i);
    cyc_i <= 1'b1; stb_i <= 1'b1; we_i <= w; adr_i <= ad; dat_i <= d;
    k = 0;
    do begin @(negedge clk_i); k++; end while (ack_o !== 1'b1 && k < 100);
    // ack is sampled at this edge: the write lands, read data is taken
    @(posedge clk_i);
    `CHK("bus ack", 1'b1, ack_o)
    q = dat_o;
    cyc_i <= 1'b0; stb_i <= 1'b0; we_i <= 1'b0;
  endtask
  // ask the source for a new pin level
  task automatic pin_set(input logic v);
    @(posedge clk_i);
    go <= 1'b1; lvl <= v;
    @(posedge clk_i);
    go <= 1'b0;
  endtask
  // clocks until the output pin next changes
  task automatic to_toggle(output int c);
    logic s;
    s = tpin;
    c = 0;
    do begin @(posedge clk_i); c++; @(negedge clk_i); end
      while (tpin === s && c < 1000);
  endtask
  task automatic do_reset();
    @(posedge clk_i);
    rst_i <= 1'b1;
    repeat (5) @(posedge clk_i);
    rst_i <= 1'b0;
    rl = 16'(($random(seed) & 31) + 8);
    wb(1'b1, rtg_pkg::RELOAD_OFF, {16'($random(seed)), rl});
  endtask
  task automatic print_verdict();
    $display("comparisons %0d mismatches %0d", cmp_count, fails);
    if (fails == 0 && cmp_count > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask

  initial begin
    clk_i = 1'b0;
    forever #12.5 clk_i = ~clk_i;
  end
  // hang guard, well beyond the length of all tests
  initial begin
    #1500000;
    fails++;
    $display("timeout");
    print_verdict();
  end

  ////////////////////////////////////////////////////////////////////////
  initial begin
    seed = 82; fails = 0; cmp_count = 0; rst_i = 1'b1; cyc_i = 1'b0;
    stb_i = 1'b0; we_i = 1'b0; adr_i = 8'h00; sel_i = 4'hf;
    dat_i = 32'h0000_0000; go = 1'b0; lvl = 1'b0;
    // reset values, the written reload value and an unmapped address
    do_reset();
    wb(1'b0, rtg_pkg::CSR_OFF, 0); `CHK("csr", 32'h0000_0000, q)
    wb(1'b0, rtg_pkg::COUNT_OFF, 0); `CHK("count", 32'h0000_0000, q)
    wb(1'b0, rtg_pkg::RELOAD_OFF, 0); `CHK("reload", {16'h0000, rl}, q)
    wb(1'b0, 8'h0c, 0); `CHK("unmapped", 32'h0000_0000, q)
    `CHK("out pin", 1'b0, tpin)
    $display("test reset done");
    // software trigger, reload, toggle, flag and interrupt
    wb(1'b1, rtg_pkg::CSR_OFF, csr(rtg_pkg::MODE_SW, 1, 1, 1));
    to_toggle(n); `CHK("sw delay", exp_sw(rl), n)
    `CHK("out pin", 1'b1, tpin)
    `CHK("irq", 1'b1, irq_o)
    to_toggle(n); `CHK("period", int'(rl) + 1, n)
    `CHK("out pin", 1'b0, tpin)
    wb(1'b0, rtg_pkg::CSR_OFF, 0); `CHK("csr", 32'h0000_000e, q)
    wb(1'b1, rtg_pkg::CSR_OFF, csr(rtg_pkg::MODE_SW, 1, 1, 0));
    @(negedge clk_i); `CHK("irq clr", 1'b0, irq_o)
    $display("test software trigger done");
    // edge modes: ignored while disabled, then start on the valid edge
    for (int i = 1; i <= 3; i++) begin
      m = 3'(i);
      do_reset();
      wb(1'b1, rtg_pkg::CSR_OFF, csr(m, 0, 0, 0));
      pin_set(1'b1);
      pin_set(1'b0);
      repeat (int'(rl) + 6) @(posedge clk_i);
      `CHK("no start", 1'b0, tpin)
      if (m == rtg_pkg::MODE_FALL) pin_set(1'b1);
      wb(1'b1, rtg_pkg::CSR_OFF, csr(m, 0, 1, 0));
      pin_set(m != rtg_pkg::MODE_FALL);
      to_toggle(n); `CHK("ext delay", exp_ext(rl), n)
      `CHK("irq masked", 1'b0, irq_o)
      $display("test edge mode %0d done", m);
    end
    // gate modes: start only by software, count only at active level
    for (int i = 4; i <= 5; i++) begin
      m = 3'(i);
      a = (m == rtg_pkg::MODE_GATE_HI);
      do_reset();
      pin_set(!a);
      wb(1'b1, rtg_pkg::CSR_OFF, csr(m, 0, 1, 0));
      pin_set(a);
      repeat (int'(rl) + 6) @(posedge clk_i);
      `CHK("gate no start", 1'b0, tpin)
      pin_set(!a);
      repeat (4) @(posedge clk_i);
      wb(1'b1, rtg_pkg::CSR_OFF, csr(m, 0, 1, 1));
      wb(1'b0, rtg_pkg::COUNT_OFF, 0);
      `CHK("gate load", {16'h0000, rl}, q)
      pin_set(a);
      to_toggle(n);
      `CHK("gate run", 1'b1, n > int'(rl) && n <= int'(rl) + 6)
      pin_set(!a);
      repeat (4) @(posedge clk_i);
      wb(1'b0, rtg_pkg::COUNT_OFF, 0);
      q1 = q;
      repeat (5) @(posedge clk_i);
      wb(1'b0, rtg_pkg::COUNT_OFF, 0); `CHK("gate hold", q1, q)
      $display("test gate mode %0d done", m);
    end
    print_verdict();
  end
endmodule // reload_timer_trigger_gate_bench

/* dv/rtg_trig_src.sv */
// trigger/gate source standing on the far side of the trigger input pin
module rtg_trig_src #(
  parameter int HOLD = 2
) (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // level request from the bench
  input wire logic go_i,
  input wire logic lvl_i,
  // pin toward the timer
  output logic pin_o
);
  int hold; // clocks left before the pin may change again
  logic pend; // a request waits for the hold to run out
  logic want; // level of the waiting request

  ////////////////////////////////////////////////////////////////////////
  // every level stands at least HOLD+1 clocks, so no pulse is too short
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pin_o <= 1'b0;
      hold <= 0;
      pend <= 1'b0;
      want <= 1'b0;
    end else begin
      if (go_i) begin
        pend <= 1'b1;
        want <= lvl_i;
      end
      if (hold != 0) begin
        hold <= hold - 1;
      end else if (go_i || pend) begin
        pin_o <= go_i ? lvl_i : want;
        hold <= HOLD;
        pend <= 1'b0;
      end
    end
  end
endmodule // rtg_trig_src

/* hw/rtg_cnt_if.sv */
// counter control bundle between the control logic and the down counter
interface rtg_cnt_if #(
  parameter int W = 16
);
  logic load; // load reload value this cycle
  logic dec; // count down this cycle
  logic [W-1:0] reload; // stored reload value
  logic [W-1:0] count; // current counter value
  logic underflow; // zero being counted past this cycle
  logic toggle; // toggle waveform state

  modport ctrl (output load, output dec, output reload,
                input count, input underflow, input toggle);
  modport cnt (input load, input dec, input reload,
               output count, output underflow, output toggle);
endinterface

/* hw/rtg_down_counter.sv */
// down counter with reload on underflow and toggle output
module rtg_down_counter #(
  parameter int W = 16
) (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // control bundle
  rtg_cnt_if.cnt c
);

  logic [W-1:0] count; // counter value
  logic toggle; // toggle waveform
  logic [W-1:0] next_count;
  logic next_toggle;

  initial begin
    if (W < 2 || W > 32) $error("rtg_down_counter: W out of range");
  end

  ////////////////////////////////////////////////////////////////////////
  // next counter value: load wins over counting
  always_comb begin
    next_count = count;
    next_toggle = toggle;
    if (c.load) begin
      next_count = c.reload;
    end else if (c.dec) begin
      if (count == '0) begin
        next_count = c.reload;
        next_toggle = ~toggle;
      end else begin
        next_count = count - W'(1);
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      count <= rtg_pkg::COUNT_RST[W-1:0];
      toggle <= 1'b0;
    end else begin
      count <= next_count;
      toggle <= next_toggle;
    end
  end

  assign c.count = count;
  assign c.toggle = toggle;
  assign c.underflow = c.dec & ~c.load & (count == '0);

endmodule // rtg_down_counter

/* hw/rtg_pin_sense.sv */
// samples the trigger input pin, gives a registered edge pulse and gate
module rtg_pin_sense (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // pin and mode
  input wire logic pin_i,
  input wire logic [2:0] mode_i,
  // results
  output logic edge_o,
  output logic gate_active_o
);

  logic pin_now; // pin as sampled this cycle
  logic pin_old; // pin one cycle earlier
  logic edge_q; // registered valid edge pulse
  logic next_pin_now;
  logic next_pin_old;
  logic next_edge_q;

  ////////////////////////////////////////////////////////////////////////
  // edge detection from two samples, result registered once more
  always_comb begin
    next_pin_now = pin_i;
    next_pin_old = pin_now;
    next_edge_q = rtg_pkg::rtg_edge_hit(mode_i, pin_now & ~pin_old,
                                        ~pin_now & pin_old);
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pin_now <= 1'b0;
      pin_old <= 1'b0;
      edge_q <= 1'b0;
    end else begin
      pin_now <= next_pin_now;
      pin_old <= next_pin_old;
      edge_q <= next_edge_q;
    end
  end

  assign edge_o = edge_q;
  // active gate level chosen by the mode
  assign gate_active_o = (mode_i == rtg_pkg::MODE_GATE_HI) ? pin_now
                                                           : ~pin_now;

endmodule // rtg_pin_sense

/* hw/rtg_pkg.sv */
package rtg_pkg;

  ////////////////////////////////////////////////////////////////////////
  // timing: machine clock and trigger-to-load delays, in picoseconds
  localparam int CLK_PS = 25000; // 40 MHz machine clock
  localparam int SW_LOAD_PS = 25000; // 1T
  localparam int EXT_LOAD_MIN_PS = 50000; // 2T
  localparam int EXT_LOAD_MAX_PS = 62500; // 2.5T
  localparam int SW_LOAD_CYC = (SW_LOAD_PS + CLK_PS - 1) / CLK_PS;
  localparam int EXT_LOAD_MIN_CYC = (EXT_LOAD_MIN_PS + CLK_PS - 1) / CLK_PS;
  localparam int EXT_LOAD_MAX_CYC = EXT_LOAD_MAX_PS / CLK_PS;

  ////////////////////////////////////////////////////////////////////////
  // register map (byte offsets on the bus)
  localparam logic [7:0] CSR_OFF = 8'h00; // control_status_register
  localparam logic [7:0] RELOAD_OFF = 8'h04; // reload_value_register
  localparam logic [7:0] COUNT_OFF = 8'h08; // live counter value

  // control_status_register fields
  localparam int TRG_BIT = 0; // software_trigger_bit, reads zero
  localparam int COUNT_ENABLE_BIT_BIT = 1; // count_enable_bit
  localparam int UF_BIT = 2; // underflow_flag, write 0 clears
  localparam int UNDERFLOW_IRQ_ENABLE_BIT = 3; // underflow_irq_enable
  localparam int MODE_LSB = 4; // operation_mode_bits [6:4]
  localparam int MODE_W = 3;

  // reset values
  localparam logic [15:0] RELOAD_RST = 16'h0000;
  localparam logic [15:0] COUNT_RST = 16'h0000;
  localparam logic [2:0] MODE_RST = 3'h0;

  ////////////////////////////////////////////////////////////////////////
  // operation_mode_bits encodings
  localparam logic [2:0] MODE_SW = 3'h0; // software trigger only
  localparam logic [2:0] MODE_RISE = 3'h1; // pin rising edge
  localparam logic [2:0] MODE_FALL = 3'h2; // pin falling edge
  localparam logic [2:0] MODE_BOTH = 3'h3; // pin both edges
  localparam logic [2:0] MODE_GATE_LO = 3'h4; // gate, low active
  localparam logic [2:0] MODE_GATE_HI = 3'h5; // gate, high active

  // run state of the counter
  typedef enum logic [0:0] {
    RTG_IDLE = 1'b0,
    RTG_RUN = 1'b1
  } rtg_run_e;

  // true for the two gate modes
  function automatic logic rtg_is_gate(input logic [2:0] mode);
    return (mode == MODE_GATE_LO) || (mode == MODE_GATE_HI);
  endfunction

  // true when the seen pin edge is one the mode asks for
  function automatic logic rtg_edge_hit(input logic [2:0] mode,
                                        input logic rise,
                                        input logic fall);
    case (mode)
      MODE_RISE: return rise;
      MODE_FALL: return fall;
      MODE_BOTH: return rise | fall;
      default: return 1'b0;
    endcase
  endfunction

endpackage

/* hw/rtg_reload_timer.sv */
// reload timer: wishbone registers, trigger and gate control
//
// The placing of the registers and the Wishbone slave port are this design's own decisions.
module rtg_reload_timer #(
  parameter int CNT_W = 16
) (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // wishbone classic slave
  input wire logic cyc_i,
  input wire logic stb_i,
  input wire logic we_i,
  input wire logic [7:0] adr_i,
  input wire logic [3:0] sel_i,
  input wire logic [31:0] dat_i,
  output logic [31:0] dat_o,
  output logic ack_o,
  // timer pins
  input wire logic trigger_input_pin_i,
  output logic timer_output_pin_o,
  // interrupt request
  output logic irq_o
);

  // the upper reload byte lane needs at least nine counter bits
  initial begin
    if (CNT_W < 9 || CNT_W > 16) $error("rtg_reload_timer: bad CNT_W");
  end

  ////////////////////////////////////////////////////////////////////////
  // declarations
  rtg_cnt_if #(.W(CNT_W)) cif ();

  logic ack_q; // bus answer, one cycle after request
  logic [31:0] rdata; // registered read data
  logic count_enable_bit; // count_enable_bit
  logic uf; // underflow_flag
  logic underflow_irq_enable; // underflow_irq_enable
  logic [2:0] mode; // operation_mode_bits
  logic [CNT_W-1:0] reload; // reload_value_register
  logic sw_trig_q; // software trigger written last cycle
  rtg_pkg::rtg_run_e state; // counting started or not
  logic pin_edge; // valid trigger edge pulse
  logic gate_active; // gate pin at active level
  logic wr_hit; // write takes effect this edge
  logic wr_csr; // write to control register, low byte
  logic wr_rld; // write to reload register
  logic start; // trigger accepted this cycle
  logic gating; // mode is a gate mode

  logic next_ack_q;
  logic [31:0] next_rdata;
  logic next_count_enable_bit;
  logic next_uf;
  logic next_underflow_irq_enable;
  logic [2:0] next_mode;
  logic [CNT_W-1:0] next_reload;
  logic next_sw_trig_q;
  rtg_pkg::rtg_run_e next_state;

  ////////////////////////////////////////////////////////////////////////
  // sub-blocks
  rtg_pin_sense u_pin (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .pin_i(trigger_input_pin_i),
    .mode_i(mode),
    .edge_o(pin_edge),
    .gate_active_o(gate_active)
  );

  rtg_down_counter #(.W(CNT_W)) u_cnt (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .c(cif.cnt)
  );

  ////////////////////////////////////////////////////////////////////////
  // bus decode: write lands on the edge where ack is high
  assign wr_hit = cyc_i & stb_i & we_i & ack_q;
  assign wr_csr = wr_hit & sel_i[0] & (adr_i == rtg_pkg::CSR_OFF);
  assign wr_rld = wr_hit & (adr_i == rtg_pkg::RELOAD_OFF);

  // bus answer and read data
  always_comb begin
    next_ack_q = cyc_i & stb_i & ~ack_q;
    next_rdata = rdata;
    if (cyc_i & stb_i & ~ack_q) begin
      case (adr_i)
        rtg_pkg::CSR_OFF: begin
          next_rdata = 32'h0000_0000;
          next_rdata[rtg_pkg::COUNT_ENABLE_BIT_BIT] = count_enable_bit;
          next_rdata[rtg_pkg::UF_BIT] = uf;
          next_rdata[rtg_pkg::UNDERFLOW_IRQ_ENABLE_BIT] = underflow_irq_enable;
          next_rdata[rtg_pkg::MODE_LSB +: rtg_pkg::MODE_W] = mode;
        end
        rtg_pkg::RELOAD_OFF: next_rdata = 32'(reload);
        rtg_pkg::COUNT_OFF: next_rdata = 32'(cif.count);
        // unmapped: answered, reads zero
        default: next_rdata = 32'h0000_0000;
      endcase
    end
  end

  // register the answer and the read word
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_q <= 1'b0;
      rdata <= 32'h0000_0000;
    end else begin
      ack_q <= next_ack_q;
      rdata <= next_rdata;
    end
  end

  assign ack_o = ack_q;
  assign dat_o = rdata;

  ////////////////////////////////////////////////////////////////////////
  // control and status register contents
  always_comb begin
    next_count_enable_bit = count_enable_bit;
    next_underflow_irq_enable = underflow_irq_enable;
    next_mode = mode;
    next_reload = reload;
    next_sw_trig_q = 1'b0;
    next_uf = uf;
    if (wr_csr) begin
      next_count_enable_bit = dat_i[rtg_pkg::COUNT_ENABLE_BIT_BIT];
      next_underflow_irq_enable = dat_i[rtg_pkg::UNDERFLOW_IRQ_ENABLE_BIT];
      next_mode = dat_i[rtg_pkg::MODE_LSB +: rtg_pkg::MODE_W];
      // trigger pulse, one cycle ahead of the load
      next_sw_trig_q = dat_i[rtg_pkg::TRG_BIT];
      // writing zero clears the flag, writing one leaves it
      if (!dat_i[rtg_pkg::UF_BIT]) begin
        next_uf = 1'b0;
      end
    end
    if (wr_rld) begin
      if (sel_i[0]) begin
        next_reload[7:0] = dat_i[7:0];
      end
      if (sel_i[1]) begin
        next_reload[CNT_W-1:8] = dat_i[CNT_W-1:8];
      end
    end
    // a new underflow wins over a clear in the same cycle
    if (cif.underflow) begin
      next_uf = 1'b1;
    end
  end

  // register the control fields and the trigger pulse
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      count_enable_bit <= 1'b0;
      uf <= 1'b0;
      underflow_irq_enable <= 1'b0;
      mode <= rtg_pkg::MODE_RST;
      reload <= rtg_pkg::RELOAD_RST[CNT_W-1:0];
      sw_trig_q <= 1'b0;
    end else begin
      count_enable_bit <= next_count_enable_bit;
      uf <= next_uf;
      underflow_irq_enable <= next_underflow_irq_enable;
      mode <= next_mode;
      reload <= next_reload;
      sw_trig_q <= next_sw_trig_q;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // trigger acceptance and run state
  assign gating = rtg_pkg::rtg_is_gate(mode);
  // gate modes start from software only; edge modes take both
  assign start = count_enable_bit & (sw_trig_q | (pin_edge & ~gating));

  always_comb begin
    next_state = state;
    case (state)
      rtg_pkg::RTG_IDLE: begin
        if (start) begin
          next_state = rtg_pkg::RTG_RUN;
        end
      end
      rtg_pkg::RTG_RUN: begin
        if (!count_enable_bit) begin
          next_state = rtg_pkg::RTG_IDLE;
        end
      end
      default: next_state = rtg_pkg::RTG_IDLE;
    endcase
  end

  // register the run state
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state <= rtg_pkg::RTG_IDLE;
    end else begin
      state <= next_state;
    end
  end

  // counter drive: load on trigger, count while running and gate open
  assign cif.load = start;
  assign cif.dec = (state == rtg_pkg::RTG_RUN) & count_enable_bit &
                   (~gating | gate_active);
  assign cif.reload = reload;

  assign timer_output_pin_o = cif.toggle;
  assign irq_o = uf & underflow_irq_enable;

  ////////////////////////////////////////////////////////////////////////
  // assertions
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  // trigger to load timing
  a_sw_load_delay: assert property (
    wr_csr && dat_i[rtg_pkg::TRG_BIT] && dat_i[rtg_pkg::COUNT_ENABLE_BIT_BIT] && !wr_rld
    |-> ##1 cif.load ##1 cif.count == $past(reload))
    else $error("software trigger did not load reload value in 1T");

  a_edge_start_run: assert property (
    count_enable_bit && !gating && pin_edge && !wr_csr |=> state == rtg_pkg::RTG_RUN)
    else $error("valid pin edge did not start counting");

  a_ext_load_delay: assert property (
    mode == rtg_pkg::MODE_RISE && count_enable_bit && $rose(trigger_input_pin_i)
    && !wr_csr ##1 !wr_csr |-> ##1 cif.load)
    else $error("pin edge did not load reload value in 2T");

  a_gate_no_pin_start: assert property (
    gating && state == rtg_pkg::RTG_IDLE && !sw_trig_q
    |=> state == rtg_pkg::RTG_IDLE)
    else $error("gate mode started without software trigger");

  a_gate_counts_down: assert property (
    gating && state == rtg_pkg::RTG_RUN && count_enable_bit && gate_active
    && !cif.load && cif.count != '0
    |=> cif.count == $past(cif.count) - CNT_W'(1))
    else $error("open gate did not count down");

  a_gate_hold_value: assert property (
    gating && !gate_active && !cif.load
    |=> cif.count == $past(cif.count))
    else $error("closed gate changed the count");

  a_uf_reload_value: assert property (
    cif.dec && !cif.load && cif.count == '0
    |=> cif.count == $past(reload) && uf)
    else $error("underflow did not reload and flag");

  a_to_toggles: assert property (
    cif.underflow |=> timer_output_pin_o != $past(timer_output_pin_o))
    else $error("timer output pin did not invert on underflow");

  a_irq_on_uf: assert property (
    cif.underflow && underflow_irq_enable && !wr_csr |=> irq_o)
    else $error("enabled underflow gave no interrupt request");

  a_bus_ack_once: assert property (
    ack_o |=> !ack_o)
    else $error("ack held for more than one cycle");

  // start in gate mode: software trigger loads and runs
  a_sw_gate_start: assert property (
    gating && count_enable_bit && sw_trig_q && !wr_csr
    |=> state == rtg_pkg::RTG_RUN && cif.count == $past(reload))
    else $error("gate mode software trigger did not start");

  // no start while count enable is clear
  a_idle_needs_enable: assert property (
    state == rtg_pkg::RTG_IDLE && !count_enable_bit |=> state == rtg_pkg::RTG_IDLE)
    else $error("counting started with count enable clear");

  // free counting outside gate modes steps down by one
  a_run_counts_down: assert property (
    !gating && cif.dec && !cif.load && cif.count != '0
    |=> cif.count == $past(cif.count) - CNT_W'(1))
    else $error("running counter did not count down");

  // cleared enable freezes the counter
  a_stop_holds_count: assert property (
    !count_enable_bit |=> cif.count == $past(cif.count))
    else $error("counter moved with count enable clear");

  // output pin moves only on an underflow
  a_pin_holds_level: assert property (
    !cif.underflow |=> timer_output_pin_o == $past(timer_output_pin_o))
    else $error("timer output pin changed without underflow");

  // writing zero to the flag clears it when no underflow competes
  a_uf_flag_clear: assert property (
    wr_csr && !dat_i[rtg_pkg::UF_BIT] && !cif.underflow |=> !uf)
    else $error("flag clear write did not clear the flag");

  // a full reload write lands on the answer edge
  a_reload_write_lands: assert property (
    wr_rld && sel_i[0] && sel_i[1] |=> reload == CNT_W'($past(dat_i)))
    else $error("reload write did not land");

  // request pending without answer gets its answer next cycle
  a_bus_ack_answer: assert property (
    cyc_i && stb_i && !ack_o |=> ack_o)
    else $error("bus request was not answered in one cycle");

  // main scenarios
  c_sw_start: cover property (sw_trig_q && count_enable_bit ##1 state == rtg_pkg::RTG_RUN);
  c_edge_start: cover property (pin_edge && count_enable_bit && !gating);
  c_gate_pause: cover property (gating && state == rtg_pkg::RTG_RUN
                                && !gate_active);
  c_underflow: cover property (cif.underflow ##[1:40] cif.underflow);
  c_uf_irq: cover property (cif.underflow && underflow_irq_enable);

endmodule // rtg_reload_timer
